// ==== src/sadc_core.sv ====
// What this block does
// - Channel code is bits 3..0; codes 0..11 pick inputs; bits 7..4 read 0.
// - Reset clears channel select to zero; byte or bit writes allowed.
// - Each conversion samples for a fixed time, then holds until done.
// - First decision trials bit 9 at half reference; kept if input at or above.
// - Each next bit is trialled on top of decided bits; kept if input >= tap.
// - After bit 0, approximation goes to result with interrupt together.
// - Conversions repeat while the enable bit 7 of the mode register is one.
// - Mode or channel write aborts conversion; restarts from first bit if enabled.
// - Reset clears the result register to zero.
// - Result is Vin over Vref times 1024, rounded down to a whole code.
// - Hardware start and enable both set: wait for the chosen trigger edge.
// - Trigger edge may be rising, falling or both as configured.
// - In triggered mode each conversion needs its own fresh trigger edge.
// - Mode write with enable set in triggered mode aborts and rewaits edge.
// - Mode write clearing enable stops conversion at once; no result stored unless bit 0 is decided that same cycle.
// - Hardware start clear and enable set: convert without outside event.
// - Software start: store, raise interrupt, then convert again at once.
// - Software start: channel rewrite aborts and converts new channel at once.
// - Time field picks 288..48 clocks; power-down bit adds half as settling.
// - Edge field: 0 none, 1 falling, 2 rising, 3 both edges.
// - Reset clears mode register: disabled, software start.
// - A result read in progress goes first; new result is written after.
module sadc_core
   import sadc_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              comp_above_i,
   input  wire logic              ext_trigger_pin_i,
   output logic      [9:0]        tap_code_o,
   output logic                   sample_hold_o,
   output logic      [3:0]        channel_o,
   output logic                   comparator_on_o,
   output logic                   conv_done_irq_o
);

   sadc_regs_t seq_reg;
   sadc_regs_t seq_next;

   // Decoded strobes, shared by the next-state logic and the checks
   logic        bus_acc;
   logic        wr_mode;
   logic        wr_chsel;
   logic        rd_result;
   logic        trig_hit;
   logic        slot_end;
   logic        conv_done;
   logic        restart;
   logic [9:0]  approx_final;

   // -------------------------------------------------------------------
   // Register read mux
   // -------------------------------------------------------------------
   function automatic logic [31:0] read_value(input sadc_regs_t r,
                                              input logic [2:0] addr);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (addr == OFS_MODE)
         v[7:0] = r.mode;
      else if (addr == OFS_CHSEL)
         v[3:0] = r.chsel;
      else if (addr == OFS_RESULT)
         v[9:0] = r.result;
      else if (addr == OFS_STATUS)
      begin
         v[STAT_BUSY_BIT] = (r.state == ST_STAB) || (r.state == ST_SAMPLE)
                            || (r.state == ST_CONVERT);
         v[STAT_WAIT_BIT] = (r.state == ST_WAIT_TRIG);
         v[STAT_PEND_BIT] = r.pend;
      end
      return v;
   endfunction : read_value

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb
   begin
      seq_next     = seq_reg;
      seq_next.irq = 1'h0;
      restart      = 1'h0;
      conv_done    = 1'h0;

      // Two-stage synchronisers for the pins from the analog side
      seq_next.trg_s1   = ext_trigger_pin_i;
      seq_next.trg_s2   = seq_reg.trg_s1;
      seq_next.trg_prev = seq_reg.trg_s2;
      seq_next.cmp_s1   = comp_above_i;
      seq_next.cmp_s2   = seq_reg.cmp_s1;

      // Avalon handshake: one wait cycle, then the access is taken
      bus_acc   = (avs_read_i || avs_write_i) && !seq_reg.wait_req;
      wr_mode   = bus_acc && avs_write_i && avs_byteenable_i[0]
                  && (avs_address_i == OFS_MODE);
      wr_chsel  = bus_acc && avs_write_i && avs_byteenable_i[0]
                  && (avs_address_i == OFS_CHSEL);
      rd_result = avs_read_i && (avs_address_i == OFS_RESULT);
      if ((avs_read_i || avs_write_i) && seq_reg.wait_req)
      begin
         seq_next.wait_req = 1'h0;
         seq_next.rdata    = read_value(seq_reg, avs_address_i);
      end
      else
         seq_next.wait_req = 1'h1;

      // Edge filter on the synchronised trigger
      case (seq_reg.mode[MODE_EDGE_LSB +: 2])
         EDGE_FALL: trig_hit = seq_reg.trg_prev && !seq_reg.trg_s2;
         EDGE_RISE: trig_hit = !seq_reg.trg_prev && seq_reg.trg_s2;
         EDGE_BOTH: trig_hit = seq_reg.trg_prev != seq_reg.trg_s2;
         default:   trig_hit = 1'h0;
      endcase

      // Slot timing: conversion = 12 slots, settling = 6 more slots
      slot_end = seq_reg.cyc ==
                 5'(sadc_slot_len(seq_reg.mode[MODE_TSEL_LSB +: 3]) - 5'h01);
      seq_next.cyc = slot_end ? 5'h00 : 5'(seq_reg.cyc + 5'h01);

      // Keep the trial bit when the input stands at or above the tap
      approx_final = seq_reg.approx;
      if (!seq_reg.cmp_s2)
         approx_final[seq_reg.bit_idx] = 1'h0;

      // Sequencer
      case (seq_reg.state)
         ST_IDLE:
         begin
            seq_next.cyc = 5'h00;
         end
         ST_WAIT_TRIG:
         begin
            // Edges are only looked at here, never during a conversion
            seq_next.cyc = 5'h00;
            if (trig_hit)
            begin
               seq_next.state = sadc_begin(seq_reg.mode);
               restart        = 1'h1;
            end
         end
         ST_STAB:
         begin
            // Comparator settles for half the conversion length
            if (slot_end)
            begin
               seq_next.step = 4'(seq_reg.step + 4'h1);
               if (seq_reg.step == 4'(STAB_SLOTS - 4'h1))
               begin
                  seq_next.state = ST_SAMPLE;
                  restart        = 1'h1;
               end
            end
         end
         ST_SAMPLE:
         begin
            if (slot_end)
            begin
               seq_next.step = 4'(seq_reg.step + 4'h1);
               if (seq_reg.step == 4'(SAMPLE_SLOTS - 4'h1))
               begin
                  seq_next.state   = ST_CONVERT;
                  seq_next.approx  = APPROX_FIRST;
                  seq_next.bit_idx = APPROX_TOP_IDX;
                  restart          = 1'h1;
               end
            end
         end
         ST_CONVERT:
         begin
            // One decision per slot, using the comparator at slot end
            if (slot_end)
            begin
               seq_next.approx = approx_final;
               if (seq_reg.bit_idx == 4'h0)
               begin
                  conv_done      = 1'h1;
                  seq_next.state = sadc_restart(seq_reg.mode);
                  restart        = 1'h1;
               end
               else
               begin
                  seq_next.bit_idx = 4'(seq_reg.bit_idx - 4'h1);
                  seq_next.approx[seq_reg.bit_idx - 4'h1] = 1'h1;
               end
            end
         end
         default:
         begin
            seq_next.state = ST_IDLE;
         end
      endcase

      // A pending result lands once the read that blocked it is gone
      if (seq_reg.pend && !rd_result)
      begin
         seq_next.result = seq_reg.pend_val;
         seq_next.irq    = 1'h1;
         seq_next.pend   = 1'h0;
      end

      // Result and interrupt leave together; a read holds them back
      if (conv_done)
      begin
         if (rd_result)
         begin
            seq_next.pend     = 1'h1;
            seq_next.pend_val = approx_final;
         end
         else
         begin
            seq_next.result = approx_final;
            seq_next.irq    = 1'h1;
            seq_next.pend   = 1'h0;
         end
      end

      // Mode and channel writes abort whatever is running and restart cleanly
      if (wr_mode)
      begin
         seq_next.mode  = avs_writedata_i[7:0];
         seq_next.state = sadc_restart(avs_writedata_i[7:0]);
         restart        = 1'h1;
      end
      if (wr_chsel)
      begin
         seq_next.chsel = avs_writedata_i[3:0];
         seq_next.state = sadc_restart(seq_next.mode);
         restart        = 1'h1;
      end

      // Fresh phase: counters start from zero
      if (restart)
      begin
         seq_next.cyc  = 5'h00;
         seq_next.step = 4'h0;
      end
      if (seq_next.state != ST_CONVERT)
      begin
         seq_next.approx  = 10'h000;
         seq_next.bit_idx = APPROX_TOP_IDX;
      end

      // Analog controls come straight from flops
      seq_next.sample  = seq_next.state == ST_SAMPLE;
      seq_next.comp_on = !seq_next.mode[MODE_PWR_BIT]
                         || (seq_next.state == ST_STAB)
                         || (seq_next.state == ST_SAMPLE)
                         || (seq_next.state == ST_CONVERT);
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         seq_reg          <= '0;
         seq_reg.state    <= ST_IDLE;
         seq_reg.mode     <= MODE_RESET;
         seq_reg.chsel    <= CHSEL_RESET;
         seq_reg.result   <= RESULT_RESET;
         seq_reg.bit_idx  <= APPROX_TOP_IDX;
         seq_reg.wait_req <= 1'h1;
         seq_reg.comp_on  <= 1'h1;
      end
      else
         seq_reg <= seq_next;
   end

   // Outputs
   assign avs_readdata_o    = seq_reg.rdata;
   assign avs_waitrequest_o = seq_reg.wait_req;
   assign tap_code_o        = seq_reg.approx;
   assign sample_hold_o     = seq_reg.sample;
   assign channel_o         = seq_reg.chsel;
   assign comparator_on_o   = seq_reg.comp_on;
   assign conv_done_irq_o   = seq_reg.irq;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking chk_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   chk_chsel_upper_zero: assert property (
      (avs_read_i && seq_reg.wait_req && avs_address_i == OFS_CHSEL)
      |=> avs_readdata_o[31:4] == 28'h0000000 && !avs_waitrequest_o)
      else $error("channel select upper bits not zero");

   chk_first_trial_mid: assert property (
      (seq_reg.state == ST_SAMPLE && seq_next.state == ST_CONVERT)
      |=> tap_code_o == APPROX_FIRST)
      else $error("first trial is not half reference");

   chk_irq_one_pulse: assert property (
      conv_done_irq_o |=> !conv_done_irq_o)
      else $error("interrupt wider than one clock");

   chk_result_with_irq: assert property (
      (conv_done && !rd_result)
      |=> conv_done_irq_o && seq_reg.result == $past(approx_final))
      else $error("result and interrupt not loaded together");

   chk_disable_stops: assert property (
      (wr_mode && !avs_writedata_i[MODE_EN_BIT])
      |=> seq_reg.state == ST_IDLE ##1 !conv_done_irq_o || seq_reg.pend)
      else $error("clearing enable did not stop conversion");

   chk_trigger_wait: assert property (
      (seq_reg.state == ST_WAIT_TRIG && !trig_hit && !wr_mode && !wr_chsel)
      |=> seq_reg.state == ST_WAIT_TRIG)
      else $error("conversion started without trigger edge");

   chk_sw_repeat: assert property (
      (conv_done && !seq_reg.mode[MODE_HWSTART_BIT]
       && seq_reg.mode[MODE_EN_BIT] && !wr_mode && !wr_chsel)
      |=> seq_reg.state == ST_STAB || seq_reg.state == ST_SAMPLE)
      else $error("software mode did not restart at once");

   chk_read_holds_result: assert property (
      rd_result |=> $stable(seq_reg.result))
      else $error("result changed under a read");

   chk_hold_in_convert: assert property (
      $fell(sample_hold_o) && seq_reg.state == ST_CONVERT
      |-> !sample_hold_o [*4])
      else $error("sample switch reopened during decisions");

   chk_slot_len_bound: assert property (
      seq_reg.cyc < sadc_slot_len(seq_reg.mode[MODE_TSEL_LSB +: 3]))
      else $error("slot counter ran past slot length");

   // An accepted edge while standing by must open a conversion
   chk_trig_starts: assert property (
      (seq_reg.state == ST_WAIT_TRIG && trig_hit && !wr_mode && !wr_chsel)
      |=> seq_reg.state == ST_STAB || seq_reg.state == ST_SAMPLE)
      else $error("trigger edge did not start conversion");

   // Software start needs no outside event
   chk_sw_start: assert property (
      (wr_mode && avs_writedata_i[MODE_EN_BIT]
       && !avs_writedata_i[MODE_HWSTART_BIT])
      |=> seq_reg.state == ST_STAB || seq_reg.state == ST_SAMPLE)
      else $error("software start did not begin conversion");

   // Channel rewrite in software mode restarts from a fresh slot
   chk_chsel_abort: assert property (
      (wr_chsel && seq_reg.mode[MODE_EN_BIT]
       && !seq_reg.mode[MODE_HWSTART_BIT])
      |=> (seq_reg.state == ST_STAB || seq_reg.state == ST_SAMPLE)
          && seq_reg.cyc == 5'h00)
      else $error("channel rewrite did not restart conversion");

   // The sample switch is closed only during the sampling phase
   chk_sample_phase: assert property (
      sample_hold_o == (seq_reg.state == ST_SAMPLE))
      else $error("sample switch outside sampling phase");

   // The tap rests at zero whenever no decision is being made
   chk_tap_rest: assert property (
      (seq_reg.state != ST_CONVERT) |-> tap_code_o == 10'h000)
      else $error("tap driven outside decisions");

endmodule : sadc_core

// ==== src/sadc_pkg.sv ====
package sadc_pkg;

   // ------------------------------------------------------------------
   // Register map (Avalon word addresses)
   // ------------------------------------------------------------------
   localparam int          ADDR_W             = 3;
   localparam logic [2:0]  OFS_MODE           = 3'h0;
   localparam logic [2:0]  OFS_CHSEL          = 3'h1;
   localparam logic [2:0]  OFS_RESULT         = 3'h2;
   localparam logic [2:0]  OFS_STATUS         = 3'h3;
   // Printed location of the channel select register in the system map
   localparam logic [31:0] CHSEL_PRINTED_OFS  = 32'hFFFFF3C2;

   // ------------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------------
   localparam int          MODE_EN_BIT        = 7;
   localparam int          MODE_HWSTART_BIT   = 6;
   localparam int          MODE_TSEL_LSB      = 3;
   localparam int          MODE_EDGE_LSB      = 1;
   localparam int          MODE_PWR_BIT       = 0;
   localparam int          STAT_BUSY_BIT      = 0;
   localparam int          STAT_WAIT_BIT      = 1;
   localparam int          STAT_PEND_BIT      = 2;
   localparam logic [7:0]  MODE_RESET         = 8'h00;
   localparam logic [3:0]  CHSEL_RESET        = 4'h0;
   localparam logic [9:0]  RESULT_RESET       = 10'h000;
   localparam logic [9:0]  APPROX_FIRST       = 10'h200;
   localparam logic [3:0]  APPROX_TOP_IDX     = 4'h9;
   localparam logic [1:0]  EDGE_FALL          = 2'h1;
   localparam logic [1:0]  EDGE_RISE          = 2'h2;
   localparam logic [1:0]  EDGE_BOTH          = 2'h3;

   // ------------------------------------------------------------------
   // Timing: conversion length in peripheral clocks, cut into slots
   // ------------------------------------------------------------------
   localparam logic [8:0]  CONV_CLK_SEL0      = 9'h120;
   localparam logic [8:0]  CONV_CLK_SEL1      = 9'h0D8;
   localparam logic [8:0]  CONV_CLK_SEL2      = 9'h0A8;
   localparam logic [8:0]  CONV_CLK_SEL3      = 9'h078;
   localparam logic [8:0]  CONV_CLK_SEL4      = 9'h060;
   localparam logic [8:0]  CONV_CLK_SEL5      = 9'h048;
   localparam logic [8:0]  CONV_CLK_SEL6      = 9'h03C;
   localparam logic [8:0]  CONV_CLK_SEL7      = 9'h030;
   localparam logic [8:0]  SLOTS_PER_CONV     = 9'h00C;
   localparam logic [3:0]  SAMPLE_SLOTS       = 4'h2;
   localparam logic [3:0]  STAB_SLOTS         = 4'h6;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_STAB,
      ST_SAMPLE,
      ST_CONVERT
   } sadc_state_t;

   typedef struct packed {
      sadc_state_t state;
      logic [7:0]  mode;
      logic [3:0]  chsel;
      logic [9:0]  result;
      logic [9:0]  approx;
      logic [3:0]  bit_idx;
      logic [3:0]  step;
      logic [4:0]  cyc;
      logic        pend;
      logic [9:0]  pend_val;
      logic        trg_s1;
      logic        trg_s2;
      logic        trg_prev;
      logic        cmp_s1;
      logic        cmp_s2;
      logic        wait_req;
      logic [31:0] rdata;
      logic        irq;
      logic        sample;
      logic        comp_on;
   } sadc_regs_t;

   // Cycles in one slot; every table entry divides evenly by 12
   function automatic logic [4:0] sadc_slot_len(input logic [2:0] sel);
      logic [8:0] clk;
      case (sel)
         3'h0:    clk = CONV_CLK_SEL0;
         3'h1:    clk = CONV_CLK_SEL1;
         3'h2:    clk = CONV_CLK_SEL2;
         3'h3:    clk = CONV_CLK_SEL3;
         3'h4:    clk = CONV_CLK_SEL4;
         3'h5:    clk = CONV_CLK_SEL5;
         3'h6:    clk = CONV_CLK_SEL6;
         default: clk = CONV_CLK_SEL7;
      endcase
      return 5'(clk / SLOTS_PER_CONV);
   endfunction : sadc_slot_len

   // First phase of a conversion once it is allowed to run
   function automatic sadc_state_t sadc_begin(input logic [7:0] mode);
      if (mode[MODE_PWR_BIT])
         return ST_STAB;
      else
         return ST_SAMPLE;
   endfunction : sadc_begin

   // Where the sequencer goes after a write or a finished conversion
   function automatic sadc_state_t sadc_restart(input logic [7:0] mode);
      if (!mode[MODE_EN_BIT])
         return ST_IDLE;
      else if (mode[MODE_HWSTART_BIT])
         return ST_WAIT_TRIG;
      else
         return sadc_begin(mode);
   endfunction : sadc_restart

endpackage : sadc_pkg

// ==== test/sadc_analog_model.sv ====
module sadc_analog_model
   import sadc_pkg::*;
(
   input  wire logic         sys_clk_i,
   input  wire logic [119:0] level_i,
   input  wire logic [9:0]   tap_code_i,
   input  wire logic         sample_hold_i,
   input  wire logic [3:0]   channel_i,
   input  wire logic         comparator_on_i,
   output logic              comp_above_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held_reg = 10'h000;
   logic       junk_reg = 1'b0;
   // Follow the chosen input while sampling, freeze it while holding
   always @(posedge sys_clk_i)
   begin
      if (sample_hold_i && channel_i < 4'hC)
         held_reg <= level_i[channel_i*10 +: 10];
      junk_reg <= ~junk_reg;
   end
   // Powered-off comparator toggles so a stray read cannot look right
   assign comp_above_o = comparator_on_i ? (held_reg >= tap_code_i)
                                         : junk_reg;
endmodule : sadc_analog_model

// ==== test/tb_sar_adc_sequencer.sv ====
module tb_sar_adc_sequencer;
   import sadc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Design, far side and bench state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [3:0] ch;
      logic [9:0] lv;
      logic [8:0] per;
   } sadc_row_t;
   logic              sys_clk_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic              rd = 1'b0;
   logic              wr = 1'b0;
   logic [31:0]       wdat = '0;
   logic [3:0]        be = 4'hF;
   logic [31:0]       rdat;
   logic              wreq;
   logic              cmp;
   logic              hw_start_select = 1'b0;
   logic [9:0]        tap;
   logic              smp;
   logic [3:0]        chan;
   logic              con;
   logic              irq;
   logic [119:0]      lvl = '0;
   logic [31:0]       rv;
   int                n;
   int                n_errors = 0;
   int                samples_checked = 0;
   int                cyc_cnt = 0;
   sadc_row_t         rows [9] = '{
      '{8'h80, 4'h0, 10'h000, 9'h120}, '{8'h88, 4'hB, 10'h3FF, 9'h0D8},
      '{8'h90, 4'h3, 10'h200, 9'h0A8}, '{8'h98, 4'h5, 10'h1FF, 9'h078},
      '{8'hA0, 4'h7, 10'h155, 9'h060}, '{8'hA8, 4'h9, 10'h2AA, 9'h048},
      '{8'hB0, 4'h1, 10'h001, 9'h03C}, '{8'hB8, 4'hA, 10'h3FE, 9'h030},
      '{8'hB9, 4'h6, 10'h123, 9'h048}};

   sadc_core sadc_core_i (
      .sys_clk_i         (sys_clk_i),
      .rstn_i            (rstn_i),
      .avs_address_i     (adr),
      .avs_read_i        (rd),
      .avs_write_i       (wr),
      .avs_writedata_i   (wdat),
      .avs_byteenable_i  (be),
      .avs_readdata_o    (rdat),
      .avs_waitrequest_o (wreq),
      .comp_above_i      (cmp),
      .ext_trigger_pin_i (hw_start_select),
      .tap_code_o        (tap),
      .sample_hold_o     (smp),
      .channel_o         (chan),
      .comparator_on_o   (con),
      .conv_done_irq_o   (irq)
   );

   sadc_analog_model sadc_analog_model_i (
      .sys_clk_i       (sys_clk_i),
      .level_i         (lvl),
      .tap_code_i      (tap),
      .sample_hold_i   (smp),
      .channel_i       (chan),
      .comparator_on_i (con),
      .comp_above_o    (cmp)
   );

   // Free-running 20 MHz clock
   always #25 sys_clk_i = ~sys_clk_i;

   // Hang guard: well above the few thousand cycles the tests need
   always @(posedge sys_clk_i)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         n_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // One Avalon access; held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk_i);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      // Waitrequest is read at the rising edge, before it updates
      do
      begin
         @(posedge sys_clk_i);
         k++;
      end
      while (wreq !== 1'b0 && k < 50);
      check(k < 50, 1, "bus answer");
      rv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   // Counts settled cycles until the interrupt pulse, or up to lim
   task automatic wait_irq(input int lim, output int c);
      c = 0;
      do
      begin
         @(negedge sys_clk_i);
         c++;
      end
      while (irq !== 1'b1 && c < lim);
   endtask : wait_irq

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      bus(0, OFS_MODE, 0);
      check(rv, MODE_RESET, "mode reset");
      bus(0, OFS_CHSEL, 0);
      check(rv, 32'h0, "chsel reset");
      bus(0, OFS_RESULT, 0);
      check(rv, 32'h0, "result reset");
      bus(0, 3'h5, 0);
      check(rv, 32'h0, "unmapped");
      check(irq, 1'b0, "irq reset");
      bus(1, OFS_CHSEL, 32'hFF);
      be <= 4'hE;
      bus(1, OFS_CHSEL, 32'h03);
      be <= 4'hF;
      bus(0, OFS_CHSEL, 0);
      check(rv, 32'h0F, "chsel width");
      check(chan, 4'hF, "channel out");
      $display("register test done");
      // Software start, every time code and the settling option
      foreach (rows[i])
      begin
         lvl[rows[i].ch*10 +: 10] <= rows[i].lv;
         bus(1, OFS_CHSEL, rows[i].ch);
         bus(1, OFS_MODE, rows[i].mode);
         wait_irq(800, n);
         wait_irq(800, n);
         check(n, rows[i].per, "period");
         @(negedge sys_clk_i);
         check(irq, 1'b0, "irq width");
         check(chan, rows[i].ch, "channel");
         bus(0, OFS_RESULT, 0);
         check(rv, rows[i].lv, "result");
         bus(1, OFS_MODE, 0);
         $display("row %0d done", i);
      end
      // Hardware start with each edge code; pin spaced beyond a conversion
      lvl[9:0] <= 10'h2C1;
      bus(1, OFS_CHSEL, 0);
      for (int e = 0; e < 4; e++)
      begin
         bus(1, OFS_MODE, 32'hF8 | (e << 1));
         wait_irq(100, n);
         check(n, 100, "standby");
         for (int s = 1; s >= 0; s--)
         begin
            @(posedge sys_clk_i);
            hw_start_select <= s[0];
            wait_irq(100, n);
            check(n < 100, s ? e[1] : e[0], "edge");
            wait_irq(150, n);
            check(n, 150, "no rerun");
         end
      end
      bus(0, OFS_RESULT, 0);
      check(rv, 32'h2C1, "trig result");
      $display("trigger test done");
      // Clearing enable mid-conversion stores nothing
      lvl[19:10] <= 10'h0AB;
      bus(1, OFS_CHSEL, 1);
      bus(1, OFS_MODE, 32'hB8);
      repeat (20) @(posedge sys_clk_i);
      bus(1, OFS_MODE, 0);
      wait_irq(150, n);
      check(n, 150, "stopped");
      bus(0, OFS_RESULT, 0);
      check(rv, 32'h2C1, "no store");
      // Channel rewrite mid-conversion restarts on the new input
      lvl[29:20] <= 10'h3C5;
      bus(1, OFS_MODE, 32'hB8);
      repeat (20) @(posedge sys_clk_i);
      bus(1, OFS_CHSEL, 2);
      wait_irq(100, n);
      check(n >= 48 && n < 100, 1, "restart time");
      bus(0, OFS_RESULT, 0);
      check(rv, 32'h3C5, "new channel");
      bus(1, OFS_MODE, 0);
      $display("abort test done");
      // Mode rewrite in triggered mode waits for a fresh edge
      bus(1, OFS_MODE, 32'hFC);
      @(posedge sys_clk_i);
      hw_start_select <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      bus(1, OFS_MODE, 32'hFC);
      wait_irq(150, n);
      check(n, 150, "rewait");
      @(posedge sys_clk_i);
      hw_start_select <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      hw_start_select <= 1'b1;
      wait_irq(100, n);
      check(n < 100, 1, "rerun");
      $display("retrigger test done");
      // Reset in mid conversion clears registers, the tap and the interrupt
      bus(1, OFS_MODE, 32'hB8);
      repeat (30) @(posedge sys_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      check(tap, 10'h000, "tap in reset");
      check(irq, 1'b0, "irq in reset");
      rstn_i <= 1'b1;
      bus(0, OFS_MODE, 0);
      check(rv, MODE_RESET, "mode after reset");
      bus(0, OFS_CHSEL, 0);
      check(rv, 32'h0, "chsel after reset");
      bus(0, OFS_RESULT, 0);
      check(rv, RESULT_RESET, "result after reset");
      $display("reset test done");
      wrap_up();
   end
endmodule : tb_sar_adc_sequencer
